/* File: rtl/scmc_div_if.sv */
// Link between the mode controller and the high-speed clock divider.
`timescale 1ns/1ps
interface scmc_div_if;
    logic hs_tick;
    logic [2:0] ratio;
    logic sys_tick;
    logic [6:0] periph_tick;
    modport ctl (output hs_tick, output ratio, input sys_tick, input periph_tick);
    modport div (input hs_tick, input ratio, output sys_tick, output periph_tick);
endinterface

/* File: rtl/scmc_divider.sv */
// Glitch-free divider of the high-speed tick stream, ratios 1 to 64.
`timescale 1ns/1ps
module scmc_divider
(
    input wire logic clock_i,
    input wire logic reset_n_i,
    scmc_div_if.div dv
);
    import scmc_pkg::*;

    typedef struct packed {
        logic [5:0] free_cnt;
        logic [5:0] sys_cnt;
        logic [2:0] ratio_act;
        logic sys_tick;
        logic [6:0] periph;
    } scmc_div_s;

    scmc_div_s div_r;
    scmc_div_s div_nxt;
    logic [5:0] limit;
    logic [6:0] per_hit;

    // ------------------------------------------------------------
    // Peripheral taps f/1 .. f/64 from a free counter
    // ------------------------------------------------------------
    genvar k;
    generate
        for (k = 0; k < 7; k++)
        begin : g_tap
            if (k == 0)
            begin : g_one
                assign per_hit[k] = dv.hs_tick;
            end
            else
            begin : g_many
                assign per_hit[k] = dv.hs_tick && (&div_r.free_cnt[k-1:0]);
            end
        end
    endgenerate

    // Ratio is only taken over at the end of a full period, so no short pulse.
    always_comb
    begin
        div_nxt = div_r;
        limit = 6'((7'h01 << div_r.ratio_act) - 7'h01);
        div_nxt.sys_tick = 1'b0;
        div_nxt.periph = per_hit;
        if (dv.hs_tick)
        begin
            div_nxt.free_cnt = div_r.free_cnt + 6'h01;
            if (div_r.sys_cnt == limit)
            begin
                div_nxt.sys_tick = 1'b1;
                div_nxt.sys_cnt = 6'h00;
                div_nxt.ratio_act = (dv.ratio > SCMC_CKS_MAX_DIV) ? SCMC_CKS_MAX_DIV : dv.ratio;
            end
            else
            begin
                div_nxt.sys_cnt = div_r.sys_cnt + 6'h01;
            end
        end
    end

    // State register.
    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            div_r <= '0;
        else
            div_r <= div_nxt;
    end

    assign dv.sys_tick = div_r.sys_tick;
    assign dv.periph_tick = div_r.periph;

endmodule // scmc_divider

/* File: rtl/scmc_pkg.sv */
// Shared constants and types of the system clock and mode controller.
package scmc_pkg;

    // ------------------------------------------------------------
    // Register offsets and field positions
    // ------------------------------------------------------------
    localparam logic [1:0] SCMC_OFF_SYS_CTL = 2'h0;
    localparam logic [1:0] SCMC_OFF_FRC_CTL = 2'h1;
    localparam logic [1:0] SCMC_OFF_FXT_CTL = 2'h2;
    localparam logic [1:0] SCMC_OFF_SXT_CTL = 2'h3;
    localparam int SCMC_CKS_LSB = 5;
    localparam int SCMC_UNUSED_BIT = 4;
    localparam int SCMC_HS_SRC_BIT = 3;
    localparam int SCMC_LS_SRC_BIT = 2;
    localparam int SCMC_HS_KEEP_BIT = 1;
    localparam int SCMC_LS_KEEP_BIT = 0;
    localparam int SCMC_FREQ_LSB = 2;
    localparam int SCMC_RANGE_BIT = 2;
    localparam int SCMC_STABLE_BIT = 1;
    localparam int SCMC_ON_BIT = 0;
    localparam logic [2:0] SCMC_CKS_SLOW = 3'h7;
    localparam logic [2:0] SCMC_CKS_MAX_DIV = 3'h6;
    localparam logic [1:0] SCMC_FREQ_ALIAS = 2'h3;
    localparam logic [1:0] SCMC_FREQ_BASE = 2'h0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] SCMC_SYS_CTL_RST = 8'h00;
    localparam logic [7:0] SCMC_FRC_CTL_RST = 8'h01;
    localparam logic [7:0] SCMC_FXT_CTL_RST = 8'h00;
    localparam logic [7:0] SCMC_SXT_CTL_RST = 8'h00;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int SCMC_CLK_PERIOD_NS = 10;
    localparam int SCMC_SETTLE_NS = 1000;
    localparam int SCMC_SETTLE_CYC =
        (SCMC_SETTLE_NS + SCMC_CLK_PERIOD_NS - 1) / SCMC_CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Operating modes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SCMC_FAST           = 3'b000,
        SCMC_SLOW           = 3'b001,
        SCMC_SLEEP          = 3'b010,
        SCMC_IDLE_SLOW_ONLY = 3'b011,
        SCMC_IDLE_BOTH_ON   = 3'b100,
        SCMC_IDLE_FAST_ONLY = 3'b101
    } scmc_mode_e;

endpackage

/* File: rtl/scmc_top.sv */
// System clock selection and power-down mode controller.
`timescale 1ns/1ps

// How it works
// - Select code 0..6 gives high-speed clock divided by 1..64; code 7 the low-speed clock.
// - High-speed source bit picks fast RC at 0, fast crystal at 1.
// - Low-speed source bit picks slow RC at 0, slow crystal at 1.
// - Halt with both keep bits low enters sleep; all main oscillators stop.
// - In sleep the slow RC runs only while the watchdog is enabled.
// - Halt with only low keep bit enters idle; system clock only on slow select.
// - Halt with both keep bits enters idle with every clock running.
// - Halt with only high keep bit enters idle; system clock only on divided select.
// - Fast mode runs the core from divided high-speed clock, slow RC and selected slow source also running.
// - Slow mode keeps the high-speed oscillator running only if its enable bit says.
// - After moving to slow, enabled high-speed oscillator still feeds peripheral taps.
// - Watchdog enable forces the slow RC on whatever the low keep bit.
// - Bit 4 of the system clock control register reads zero.
// - Enabling an oscillator or changing RC frequency clears its stable flag, then sets it.
// - RC frequency code 0,1,2,3 gives 8, 12, 16, 8 MHz.
// - The move to slow mode completes only once the low-speed source is stable.
module scmc_top
(
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic [1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic halt_req_i,
    input wire logic wake_i,
    input wire logic wdt_en_i,
    input wire logic [3:0] osc_ready_i,
    input wire logic [3:0] osc_tick_i,
    output logic core_run_o,
    output scmc_pkg::scmc_mode_e mode_o,
    output logic fast_rc_en_o,
    output logic fast_xtal_en_o,
    output logic slow_xtal_en_o,
    output logic slow_rc_en_o,
    output logic [1:0] fast_rc_freq_o,
    output logic fast_xtal_range_o,
    output logic sys_tick_o,
    output logic ls_tick_o,
    output logic [6:0] periph_tick_o
);
    import scmc_pkg::*;

    typedef struct packed {
        logic [7:0] sys_ctl;
        logic [1:0] rc_freq;
        logic rc_on;
        logic xt_range;
        logic xt_on;
        logic lx_on;
        logic [2:0] stable;
        logic [2:0][7:0] wait_cnt;
        logic [2:0] en_d;
        logic [7:0] s1;
        logic [7:0] s2;
        logic [7:0] s3;
        logic [7:0] filt;
        logic slow_act;
        scmc_mode_e mode;
        logic [7:0] rdata;
    } scmc_state_s;

    scmc_state_s st_r;
    scmc_state_s st_nxt;
    scmc_div_if dv ();

    logic [7:0] edge_w;
    logic halted;
    logic hs_ok;
    logic ls_ok;
    logic hs_tick;
    logic ls_tick;
    logic hs_ready;
    logic ls_ready;
    logic sys_gate;
    logic [2:0] cks;
    logic [2:0] osc_en;
    logic freq_chg;

    // ------------------------------------------------------------
    // Decoded views of the state
    // ------------------------------------------------------------
    // A rising tick is seen only once two back stages agree high.
    assign edge_w = st_r.s2 & st_r.s3 & ~st_r.filt;
    assign cks = st_r.sys_ctl[SCMC_CKS_LSB+:3];
    assign halted = (st_r.mode != SCMC_FAST) && (st_r.mode != SCMC_SLOW);
    assign hs_ok = !halted || st_r.sys_ctl[SCMC_HS_KEEP_BIT];
    assign ls_ok = !halted || st_r.sys_ctl[SCMC_LS_KEEP_BIT];

    // Oscillator enables; the selected fast source is forced on while it clocks the core.
    assign fast_rc_en_o = hs_ok && (st_r.rc_on ||
        (!st_r.sys_ctl[SCMC_HS_SRC_BIT] && (!st_r.slow_act || halted)));
    assign fast_xtal_en_o = hs_ok && (st_r.xt_on ||
        (st_r.sys_ctl[SCMC_HS_SRC_BIT] && (!st_r.slow_act || halted)));
    assign slow_xtal_en_o = ls_ok && (st_r.lx_on || st_r.sys_ctl[SCMC_LS_SRC_BIT]);
    // Slow RC always runs in the running modes, and the watchdog overrides sleep.
    assign slow_rc_en_o = (ls_ok && (!st_r.sys_ctl[SCMC_LS_SRC_BIT] || !halted))
        || wdt_en_i;
    assign osc_en = {slow_xtal_en_o, fast_xtal_en_o, fast_rc_en_o};

    // Source selection of the tick streams.
    assign hs_tick = (st_r.sys_ctl[SCMC_HS_SRC_BIT] ? edge_w[5] : edge_w[4])
        && (st_r.sys_ctl[SCMC_HS_SRC_BIT] ? fast_xtal_en_o : fast_rc_en_o);
    assign ls_tick = (st_r.sys_ctl[SCMC_LS_SRC_BIT] ? edge_w[6] : edge_w[7])
        && (st_r.sys_ctl[SCMC_LS_SRC_BIT] ? slow_xtal_en_o : slow_rc_en_o);
    assign hs_ready = st_r.sys_ctl[SCMC_HS_SRC_BIT] ? st_r.stable[1] : st_r.stable[0];
    assign ls_ready = st_r.sys_ctl[SCMC_LS_SRC_BIT] ? st_r.stable[2] : st_r.filt[3];
    assign freq_chg = reg_wr_i && (reg_addr_i == SCMC_OFF_FRC_CTL)
        && (reg_wdata_i[SCMC_FREQ_LSB+:2] != st_r.rc_freq);

    // System clock gate per mode.
    always_comb
    begin
        case (st_r.mode)
            SCMC_FAST: sys_gate = 1'b1;
            SCMC_SLOW: sys_gate = 1'b1;
            SCMC_IDLE_SLOW_ONLY: sys_gate = st_r.slow_act;
            SCMC_IDLE_BOTH_ON: sys_gate = 1'b1;
            SCMC_IDLE_FAST_ONLY: sys_gate = !st_r.slow_act;
            default: sys_gate = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        // Pin synchronisers; the filtered value sets when stages two and three are both high, clears when they differ, and holds when both are low.
        st_nxt.s1 = {osc_tick_i, osc_ready_i};
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        st_nxt.filt = (st_r.s2 & st_r.s3) | (st_r.filt & ~(st_r.s2 ^ st_r.s3));

        // Register writes; bit 4 is never stored so it cannot read back as one.
        if (reg_wr_i)
        begin
            case (reg_addr_i)
                SCMC_OFF_SYS_CTL:
                    st_nxt.sys_ctl = reg_wdata_i & ~(8'h01 << SCMC_UNUSED_BIT);
                SCMC_OFF_FRC_CTL:
                begin
                    st_nxt.rc_freq = reg_wdata_i[SCMC_FREQ_LSB+:2];
                    st_nxt.rc_on = reg_wdata_i[SCMC_ON_BIT];
                end
                SCMC_OFF_FXT_CTL:
                begin
                    // Range may not move while the crystal enable bit is set.
                    if (!st_r.xt_on)
                        st_nxt.xt_range = reg_wdata_i[SCMC_RANGE_BIT];
                    st_nxt.xt_on = reg_wdata_i[SCMC_ON_BIT];
                end
                default:
                    st_nxt.lx_on = reg_wdata_i[SCMC_ON_BIT];
            endcase
        end

        // Read data, valid in the cycle after the strobe.
        st_nxt.rdata = 8'h00;
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                SCMC_OFF_SYS_CTL: st_nxt.rdata = st_r.sys_ctl;
                SCMC_OFF_FRC_CTL: st_nxt.rdata = {4'h0, st_r.rc_freq, st_r.stable[0], st_r.rc_on};
                SCMC_OFF_FXT_CTL: st_nxt.rdata = {5'h00, st_r.xt_range, st_r.stable[1], st_r.xt_on};
                default: st_nxt.rdata = {6'h00, st_r.stable[2], st_r.lx_on};
            endcase
        end

        // Stable flags: cleared on each start, set after settling and a ready oscillator.
        st_nxt.en_d = osc_en;
        for (int i = 0; i < 3; i++)
        begin
            if (!osc_en[i])
            begin
                st_nxt.stable[i] = 1'b0;
                st_nxt.wait_cnt[i] = 8'h00;
            end
            else if (!st_r.en_d[i] || (i == 0 && freq_chg))
            begin
                st_nxt.stable[i] = 1'b0;
                st_nxt.wait_cnt[i] = 8'(SCMC_SETTLE_CYC);
            end
            else if (st_r.wait_cnt[i] != 8'h00)
            begin
                st_nxt.wait_cnt[i] = st_r.wait_cnt[i] - 8'h01;
            end
            else if (st_r.filt[i])
            begin
                st_nxt.stable[i] = 1'b1;
            end
        end

        // Source change only at a pulse of the old source, and only onto a stable one.
        if (!st_r.slow_act && cks == SCMC_CKS_SLOW && ls_ready && dv.sys_tick)
            st_nxt.slow_act = 1'b1;
        else if (st_r.slow_act && cks != SCMC_CKS_SLOW && hs_ready && ls_tick)
            st_nxt.slow_act = 1'b0;

        // Mode sequencing.
        case (st_r.mode)
            SCMC_FAST, SCMC_SLOW:
            begin
                if (halt_req_i)
                begin
                    case (st_r.sys_ctl[SCMC_LS_KEEP_BIT+:2])
                        2'b00: st_nxt.mode = SCMC_SLEEP;
                        2'b01: st_nxt.mode = SCMC_IDLE_SLOW_ONLY;
                        2'b11: st_nxt.mode = SCMC_IDLE_BOTH_ON;
                        default: st_nxt.mode = SCMC_IDLE_FAST_ONLY;
                    endcase
                end
                else
                begin
                    st_nxt.mode = st_nxt.slow_act ? SCMC_SLOW : SCMC_FAST;
                end
            end
            SCMC_SLEEP, SCMC_IDLE_SLOW_ONLY, SCMC_IDLE_BOTH_ON, SCMC_IDLE_FAST_ONLY:
            begin
                if (wake_i)
                    st_nxt.mode = st_r.slow_act ? SCMC_SLOW : SCMC_FAST;
            end
            default: st_nxt.mode = SCMC_FAST;
        endcase
    end

    // State register; reset loads constants only.
    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            st_r <= '0;
            st_r.sys_ctl <= SCMC_SYS_CTL_RST;
            st_r.rc_on <= SCMC_FRC_CTL_RST[SCMC_ON_BIT];
            st_r.xt_on <= SCMC_FXT_CTL_RST[SCMC_ON_BIT];
            st_r.lx_on <= SCMC_SXT_CTL_RST[SCMC_ON_BIT];
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // Divider and outputs
    // ------------------------------------------------------------
    assign dv.hs_tick = hs_tick;
    assign dv.ratio = cks;

    scmc_divider u_div
    (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .dv(dv.div)
    );

    // Pulses are whole clock cycles, so a source change cannot shorten one.
    assign sys_tick_o = sys_gate && (st_r.slow_act ? ls_tick : dv.sys_tick);
    assign ls_tick_o = ls_tick && ls_ok;
    assign periph_tick_o = dv.periph_tick;
    assign core_run_o = !halted;
    assign mode_o = st_r.mode;
    assign reg_rdata_o = st_r.rdata;
    assign fast_rc_freq_o = (st_r.rc_freq == SCMC_FREQ_ALIAS) ? SCMC_FREQ_BASE
        : st_r.rc_freq;
    assign fast_xtal_range_o = st_r.xt_range;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);

    property p_sleep_off;
        st_r.mode == SCMC_SLEEP |-> !fast_rc_en_o && !fast_xtal_en_o && !slow_xtal_en_o;
    endproperty
    a_sleep_off: assert property (p_sleep_off) else $error("oscillator on in sleep");
    property p_sleep_rc;
        st_r.mode == SCMC_SLEEP |-> slow_rc_en_o == wdt_en_i;
    endproperty
    a_sleep_rc: assert property (p_sleep_rc) else $error("slow RC wrong in sleep");
    property p_wdt_rc;
        wdt_en_i |-> slow_rc_en_o;
    endproperty
    a_wdt_rc: assert property (p_wdt_rc) else $error("slow RC off with watchdog");
    property p_halt_sleep;
        halt_req_i && !halted && st_r.sys_ctl[1:0] == 2'b00 |=> st_r.mode == SCMC_SLEEP
            && !core_run_o;
    endproperty
    a_halt_sleep: assert property (p_halt_sleep) else $error("sleep not entered");
    property p_idle_slow;
        st_r.mode == SCMC_IDLE_SLOW_ONLY |-> !fast_rc_en_o && !fast_xtal_en_o
            && (!sys_tick_o || st_r.slow_act);
    endproperty
    a_idle_slow: assert property (p_idle_slow) else $error("idle slow-only wrong");
    property p_idle_both;
        st_r.mode == SCMC_IDLE_BOTH_ON |-> !core_run_o && (fast_rc_en_o || fast_xtal_en_o);
    endproperty
    a_idle_both: assert property (p_idle_both) else $error("idle both-on wrong");
    property p_idle_fast;
        st_r.mode == SCMC_IDLE_FAST_ONLY |-> !slow_xtal_en_o && (!sys_tick_o || !st_r.slow_act);
    endproperty
    a_idle_fast: assert property (p_idle_fast) else $error("idle fast-only wrong");
    property p_bit4;
        reg_rd_i && reg_addr_i == SCMC_OFF_SYS_CTL |=> !reg_rdata_o[SCMC_UNUSED_BIT];
    endproperty
    a_bit4: assert property (p_bit4) else $error("bit 4 read as one");
    property p_restart;
        $rose(fast_rc_en_o) |=> !st_r.stable[0] [*8];
    endproperty
    a_restart: assert property (p_restart) else $error("stable flag not cleared");
    property p_freq;
        st_r.rc_freq == SCMC_FREQ_ALIAS |-> fast_rc_freq_o == SCMC_FREQ_BASE;
    endproperty
    a_freq: assert property (p_freq) else $error("alias frequency wrong");
    property p_slow_entry;
        $rose(st_r.slow_act) |-> $past(ls_ready);
    endproperty
    a_slow_entry: assert property (p_slow_entry) else $error("slow before stable");
    property p_tick_short;
        sys_tick_o |=> !sys_tick_o;
    endproperty
    a_tick_short: assert property (p_tick_short) else $error("merged clock pulse");

    c_sleep: cover property (st_r.mode == SCMC_SLEEP ##[1:50] st_r.mode == SCMC_FAST);
    c_idle_both: cover property (st_r.mode == SCMC_IDLE_BOTH_ON && sys_tick_o);
    c_slow: cover property ($rose(st_r.slow_act));
    c_stable: cover property ($rose(st_r.stable[0]));

endmodule // scmc_top

/* File: testbench/scmc_osc_model.sv */
// Behavioural oscillator bank on the far side of the clock controller.
`timescale 1ns/1ps
module scmc_osc_model
(
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic [3:0] osc_en_i,
    output logic [3:0] osc_ready_o,
    output logic [3:0] osc_tick_o
);
    // Half periods in cycles: fast RC, fast crystal, slow crystal, slow RC.
    localparam int HALF [4] = '{4, 6, 48, 32};
    localparam int START = 20;
    int ph [4];
    int age [4];

    // A disabled oscillator holds its pin low and drops ready, so stale ticks cannot leak.
    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
        for (int i = 0; i < 4; i++)
        begin
            if (!reset_n_i || !osc_en_i[i])
            begin
                ph[i] <= 0;
                age[i] <= 0;
                osc_tick_o[i] <= 1'b0;
                osc_ready_o[i] <= 1'b0;
            end
            else
            begin
                age[i] <= (age[i] < START) ? age[i] + 1 : age[i];
                osc_ready_o[i] <= (age[i] >= START);
                ph[i] <= (ph[i] == HALF[i] - 1) ? 0 : ph[i] + 1;
                if (ph[i] == HALF[i] - 1)
                    osc_tick_o[i] <= ~osc_tick_o[i];
            end
        end
    end
endmodule // scmc_osc_model

/* File: testbench/tb_top.sv */
// Self-checking bench of the system clock and mode controller.
`timescale 1ns/1ps
module tb_top;
    import scmc_pkg::*;
    logic clock_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic halt = 1'b0;
    logic wake = 1'b0;
    logic wdt = 1'b0;
    logic [7:0] rdata;
    logic core_run;
    scmc_mode_e mode;
    logic [3:0] en;
    logic [3:0] rdy;
    logic [3:0] tck;
    logic [1:0] freq;
    logic sys_t;
    logic [6:0] per_t;
    logic rng;
    logic lst;
    int n_mismatch = 0;
    int tests_run = 0;
    int s;
    int h;
    int l;
    int g;
    logic [7:0] v;
    scmc_mode_e exp_mode [4] = '{SCMC_SLEEP, SCMC_IDLE_SLOW_ONLY, SCMC_IDLE_FAST_ONLY,
        SCMC_IDLE_BOTH_ON};

    scmc_top DUT (.clock_i(clock_i), .reset_n_i(reset_n_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata),
        .halt_req_i(halt), .wake_i(wake), .wdt_en_i(wdt), .osc_ready_i(rdy),
        .osc_tick_i(tck), .core_run_o(core_run), .mode_o(mode), .fast_rc_en_o(en[0]),
        .fast_xtal_en_o(en[1]), .slow_xtal_en_o(en[2]), .slow_rc_en_o(en[3]),
        .fast_rc_freq_o(freq), .fast_xtal_range_o(rng), .sys_tick_o(sys_t), .ls_tick_o(lst),
        .periph_tick_o(per_t));
    scmc_osc_model osc (.clock_i(clock_i), .reset_n_i(reset_n_i), .osc_en_i(en),
        .osc_ready_o(rdy), .osc_tick_o(tck));

    // ----------------------------------------
    // Clock and shared tasks
    // ----------------------------------------
    initial
    begin
        forever #5 clock_i = ~clock_i;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // Each access leaves one idle cycle so a strobe is never driven twice in one step.
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clock_i);
        wr_s <= 1'b0;
        @(posedge clock_i);
    endtask

    task automatic rdchk(input logic [1:0] a, input logic [7:0] e);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clock_i);
        rd_s <= 1'b0;
        // Sampled at the next edge, where the registered read data still stand.
        @(posedge clock_i);
        v = rdata;
        check({8'h00, v}, {8'h00, e});
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock_i);
    endtask

    // Counts system ticks and undivided high-speed ticks over a window.
    task automatic measure(input int n);
        s = 0;
        h = 0;
        l = 0;
        g = 0;
        repeat (n)
        begin
            @(posedge clock_i);
            s += sys_t;
            h += per_t[0];
            l += lst;
            g += per_t[6];
        end
    endtask

    task automatic pulse(input logic go_halt);
        if (go_halt)
            halt <= 1'b1;
        else
            wake <= 1'b1;
        @(posedge clock_i);
        halt <= 1'b0;
        wake <= 1'b0;
        @(posedge clock_i);
    endtask

    task automatic close_out;
        $display("Checks run %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial
    begin
        repeat (6) @(posedge clock_i);
        reset_n_i <= 1'b1;
        cyc(250);
        rdchk(2'h0, 8'h00);
        rdchk(2'h1, 8'h03);
        wr(2'h0, 8'h10);
        rdchk(2'h0, 8'h00);
        for (int c = 1; c < 5; c++)
        begin
            wr(2'h1, {4'h0, 2'(c), 2'b01});
            check({14'h0, freq}, (c == 3) ? 16'h0 : 16'(c % 4));
            rdchk(2'h1, {4'h0, 2'(c), 2'b01});
            cyc(250);
        end
        // The range bit moves while the crystal is off and holds once it runs.
        wr(2'h2, 8'h04);
        check({15'h0, rng}, 16'h1);
        wr(2'h2, 8'h01);
        rdchk(2'h2, 8'h01);
        wr(2'h3, 8'h01);
        cyc(250);
        wr(2'h2, 8'h05);
        check({15'h0, rng}, 16'h0);
        rdchk(2'h2, 8'h03);
        rdchk(2'h3, 8'h03);
        for (int k = 0; k < 7; k++)
        begin
            wr(2'h0, {3'(k), 5'h00});
            cyc(600);
            measure(4096);
            check(16'((s - (h >> k)) inside {[-1:1]}), 16'h1);
            check(16'((g - (h >> 6)) inside {[-1:1]}), 16'h1);
        end
        // Long wait: the old divide-by-64 period must end before the new ratio applies.
        wr(2'h0, 8'h08);
        cyc(900);
        measure(1200);
        check(16'(s inside {[95:105]}), 16'h1);
        for (int j = 0; j < 5; j++)
        begin
            wdt <= (j == 4);
            wr(2'h0, {6'h00, 2'(j)});
            cyc(300);
            pulse(1'b1);
            check({13'h0, mode}, {13'h0, exp_mode[j % 4]});
            check({15'h0, core_run}, 16'h0);
            measure(300);
            check(16'(s > 0), 16'(j == 2 || j == 3));
            check(16'(l > 0), 16'(j == 1 || j == 3));
            if (j % 4 == 0)
                check({12'h0, en}, {12'h0, wdt, 3'h0});
            pulse(1'b0);
            check({13'h0, mode}, {13'h0, SCMC_FAST});
        end
        wdt <= 1'b0;
        wr(2'h0, 8'he0);
        cyc(600);
        check({13'h0, mode}, {13'h0, SCMC_SLOW});
        measure(3000);
        check(16'(s inside {[44:50]}), 16'h1);
        check(16'(h > 0), 16'h1);
        check(16'(g > 0), 16'h1);
        wr(2'h0, 8'he4);
        cyc(600);
        measure(3000);
        check(16'(s inside {[29:33]}), 16'h1);
        wr(2'h1, 8'h00);
        check({15'h0, en[0]}, 16'h0);
        wr(2'h1, 8'h01);
        wr(2'h0, 8'he5);
        pulse(1'b1);
        measure(1000);
        check(16'(s > 0), 16'h1);
        pulse(1'b0);
        check({15'h0, core_run}, 16'h1);
        wr(2'h0, 8'h00);
        cyc(600);
        check({13'h0, mode}, {13'h0, SCMC_FAST});
        close_out();
    end

    // Watchdog sized at about twice the expected run length.
    initial
    begin
        #1000000;
        n_mismatch++;
        close_out();
    end
endmodule // tb_top
